// >>> core/rxd_top.sv
// Receive descriptor engine: ring walk, buffer fill, descriptor close, registers
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module rxd_top
  import rxd_pkg::*;
#(
  parameter int LEN_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_adr_o,
  output logic      [3:0]  mem_sel_o,
  output logic      [31:0] mem_dat_o,
  input  wire logic [31:0] mem_dat_i,
  input  wire logic        mem_ack_i,
  input  wire logic        rx_valid_i,
  input  wire rxd_rx_t     rx_i,
  output logic             rx_ready_o,
  output logic             irq_o
);

  if (LEN_W != 16) begin : g_chk
    $error("rxd_top: LEN_W must be 16 to fit the descriptor length field");
  end

  // Register file
  logic [1:0]           ctrl_r, ctrl_nxt;
  logic [31:0]          tbase_r, tbase_nxt;
  logic [15:0]          buflen_r, buflen_nxt;
  logic                 ack_r, ack_nxt;
  logic [31:0]          rdat_r, rdat_nxt;
  logic [31:0]          lane;
  logic                 wr_go;
  logic [RXD_EVT_W-1:0] evt_clr;
  logic                 mask_we;
  logic [RXD_EVT_W-1:0] evt_stat;
  logic [RXD_EVT_W-1:0] evt_mask;
  logic [RXD_EVT_W-1:0] set_r, set_nxt;

  // Engine state
  rxd_state_t   state_r, state_nxt;
  logic [31:0]  cur_ptr_r, cur_ptr_nxt;
  logic [31:0]  buf_ptr_r, buf_ptr_nxt;
  rxd_bd_stat_t stat_r, stat_nxt;
  logic [15:0]  cnt_r, cnt_nxt;
  logic [15:0]  total_r, total_nxt;
  logic         first_r, first_nxt;
  logic         buf_first_r, buf_first_nxt;
  logic         last_r, last_nxt;
  logic         miss_r, miss_nxt;
  rxd_err_t     err_r, err_nxt;
  logic [7:0]   byte_r, byte_nxt;
  logic         ready_r, ready_nxt;
  logic         req_r, req_nxt;
  logic         we_r, we_nxt;
  logic [31:0]  adr_r, adr_nxt;
  logic [3:0]   sel_r, sel_nxt;
  logic [31:0]  dat_r, dat_nxt;
  logic         done;
  logic         take;
  rxd_bd_stat_t close_stat;
  logic [31:0]  waddr;

  assign lane    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_go   = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign evt_clr = (wr_go && wb_adr_i == RXD_OFF_EVT) ?
                   (wb_dat_i[RXD_EVT_W-1:0] & lane[RXD_EVT_W-1:0]) : '0;
  assign mask_we = wr_go && wb_adr_i == RXD_OFF_MASK && wb_sel_i[0];

  always_comb begin
    ctrl_nxt   = ctrl_r;
    tbase_nxt  = tbase_r;
    buflen_nxt = buflen_r;
    ack_nxt    = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt   = 32'h0000_0000;
    if (wr_go) begin
      if (wb_adr_i == RXD_OFF_CTRL) begin
        ctrl_nxt = (ctrl_r & ~lane[1:0]) | (wb_dat_i[1:0] & lane[1:0]);
      end else if (wb_adr_i == RXD_OFF_TBASE) begin
        tbase_nxt = (tbase_r & ~lane) | (wb_dat_i & lane);
      end else if (wb_adr_i == RXD_OFF_BUFLEN) begin
        buflen_nxt = (buflen_r & ~lane[15:0]) | (wb_dat_i[15:0] & lane[15:0]);
      end
    end
    if (ack_nxt && !wb_we_i) begin
      if (wb_adr_i == RXD_OFF_CTRL) begin
        rdat_nxt = {30'h0000_0000, ctrl_r};
      end else if (wb_adr_i == RXD_OFF_TBASE) begin
        rdat_nxt = tbase_r;
      end else if (wb_adr_i == RXD_OFF_BUFLEN) begin
        rdat_nxt = {16'h0000, buflen_r};
      end else if (wb_adr_i == RXD_OFF_EVT) begin
        rdat_nxt = {29'h0000_0000, evt_stat};
      end else if (wb_adr_i == RXD_OFF_MASK) begin
        rdat_nxt = {29'h0000_0000, evt_mask};
      end else if (wb_adr_i == RXD_OFF_CUR) begin
        rdat_nxt = cur_ptr_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= RXD_RST_CTRL;
      tbase_r  <= RXD_RST_TBASE;
      buflen_r <= RXD_RST_BUFLEN;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      tbase_r  <= tbase_nxt;
      buflen_r <= buflen_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
    end
  end

  rxd_evt #(
    .W (RXD_EVT_W)
  ) u_evt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (set_r),
    .clr_i     (evt_clr),
    .mask_we_i (mask_we),
    .mask_i    (wb_dat_i[RXD_EVT_W-1:0]),
    .status_o  (evt_stat),
    .mask_o    (evt_mask),
    .irq_o     (irq_o)
  );

  assign done  = req_r && mem_ack_i;
  assign take  = rx_valid_i && ready_r;
  assign waddr = buf_ptr_r + {16'h0000, cnt_r};

  // Status written back on close: ownership returns to the host
  always_comb begin
    close_stat        = stat_r;
    close_stat.empty  = 1'b0;                                  // RQ2
    close_stat.last   = last_r;                                // RQ8
    close_stat.first  = buf_first_r;                           // RQ10
    close_stat.miss   = last_r && miss_r;                      // RQ11
    close_stat.err    = last_r ? err_r : '0;                   // RQ8
  end

  always_comb begin
    state_nxt     = state_r;
    cur_ptr_nxt   = cur_ptr_r;
    buf_ptr_nxt   = buf_ptr_r;
    stat_nxt      = stat_r;
    cnt_nxt       = cnt_r;
    total_nxt     = total_r;
    first_nxt     = first_r;
    buf_first_nxt = buf_first_r;
    last_nxt      = last_r;
    miss_nxt      = miss_r;
    err_nxt       = err_r;
    byte_nxt      = byte_r;
    ready_nxt     = 1'b0;
    set_nxt       = '0;
    case (state_r)
      RXD_ST_IDLE: begin
        first_nxt = 1'b1;
        total_nxt = 16'h0000;
        last_nxt  = 1'b0;
        miss_nxt  = 1'b0;
        err_nxt   = '0;
        if (!ctrl_r[RXD_CTRL_EN]) begin
          cur_ptr_nxt = tbase_r;
        end else if (rx_valid_i) begin
          state_nxt = RXD_ST_RD_STAT;
        end
      end
      RXD_ST_RD_STAT: begin
        if (done) begin
          if (mem_dat_i[RXD_BD_E_POS]) begin
            stat_nxt  = rxd_bd_stat_t'(mem_dat_i[31:16]);      // RQ1
            state_nxt = RXD_ST_RD_PTR;
          end else begin
            set_nxt[RXD_EVT_BUSY] = 1'b1;                      // RQ2
            state_nxt = RXD_ST_DROP;
            ready_nxt = 1'b1;
          end
        end
      end
      RXD_ST_RD_PTR: begin
        if (done) begin
          buf_ptr_nxt   = mem_dat_i;
          buf_first_nxt = first_r;
          first_nxt     = 1'b0;
          cnt_nxt       = 16'h0000;
          state_nxt     = RXD_ST_RECV;
          ready_nxt     = 1'b1;
        end
      end
      RXD_ST_RECV: begin
        ready_nxt = !take;
        if (take) begin
          byte_nxt = rx_i.data;
          if (total_r == 16'h0000) begin
            miss_nxt = ctrl_r[RXD_CTRL_PROM] && rx_i.miss;     // RQ11
          end
          if (rx_i.eof) begin
            last_nxt = 1'b1;                                   // RQ8
            err_nxt  = rx_i.err;
          end
          state_nxt = RXD_ST_WRB;
        end
      end
      RXD_ST_WRB: begin
        if (done) begin
          cnt_nxt   = cnt_r + 16'h0001;
          total_nxt = total_r + 16'h0001;
          if (last_r || (cnt_r + 16'h0001) >= buflen_r) begin
            state_nxt = RXD_ST_CLOSE;
          end else begin
            state_nxt = RXD_ST_RECV;
            ready_nxt = 1'b1;
          end
        end
      end
      RXD_ST_CLOSE: begin
        if (done) begin
          if (stat_r.intr) begin                               // RQ6 RQ7
            set_nxt[RXD_EVT_FRM] = last_r;
            set_nxt[RXD_EVT_BUF] = !last_r;
          end
          // Ring length is set only by the wrap flag
          if (stat_r.wrap) begin                               // RQ5
            cur_ptr_nxt = tbase_r;                             // RQ4
          end else begin
            cur_ptr_nxt = cur_ptr_r + RXD_BD_SIZE;             // RQ12
          end
          state_nxt = last_r ? RXD_ST_IDLE : RXD_ST_RD_STAT;
        end
      end
      RXD_ST_DROP: begin
        ready_nxt = 1'b1;
        if (take && rx_i.eof) begin
          ready_nxt = 1'b0;
          state_nxt = RXD_ST_IDLE;
        end
      end
      default: begin
        state_nxt = RXD_ST_IDLE;
      end
    endcase
  end

  // Memory request; drops for at least one cycle after every ack
  always_comb begin
    req_nxt = 1'b0;
    we_nxt  = 1'b0;
    adr_nxt = 32'h0000_0000;
    sel_nxt = 4'hF;
    dat_nxt = 32'h0000_0000;
    if (!done || state_nxt != state_r) begin
      case (state_nxt)
        RXD_ST_RD_STAT: begin
          req_nxt = !done;
          adr_nxt = cur_ptr_nxt;
        end
        RXD_ST_RD_PTR: begin
          req_nxt = !done;
          adr_nxt = cur_ptr_r + RXD_BD_PTR_OFS;
        end
        RXD_ST_WRB: begin
          req_nxt = !done;
          we_nxt  = 1'b1;
          adr_nxt = {waddr[31:2], 2'b00};
          sel_nxt = 4'h1 << waddr[1:0];
          dat_nxt = {4{byte_nxt}};
        end
        RXD_ST_CLOSE: begin
          req_nxt = !done;
          we_nxt  = 1'b1;
          adr_nxt = cur_ptr_r;
          dat_nxt = {close_stat, (last_r ? total_nxt : cnt_nxt)};   // RQ9
        end
        default: begin
          req_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= RXD_ST_IDLE;
      cur_ptr_r   <= RXD_RST_TBASE;
      buf_ptr_r   <= 32'h0000_0000;
      stat_r      <= '0;
      cnt_r       <= 16'h0000;
      total_r     <= 16'h0000;
      first_r     <= 1'b1;
      buf_first_r <= 1'b0;
      last_r      <= 1'b0;
      miss_r      <= 1'b0;
      err_r       <= '0;
      byte_r      <= 8'h00;
      ready_r     <= 1'b0;
      set_r       <= '0;
      req_r       <= 1'b0;
      we_r        <= 1'b0;
      adr_r       <= 32'h0000_0000;
      sel_r       <= 4'h0;
      dat_r       <= 32'h0000_0000;
    end else begin
      state_r     <= state_nxt;
      cur_ptr_r   <= cur_ptr_nxt;
      buf_ptr_r   <= buf_ptr_nxt;
      stat_r      <= stat_nxt;
      cnt_r       <= cnt_nxt;
      total_r     <= total_nxt;
      first_r     <= first_nxt;
      buf_first_r <= buf_first_nxt;
      last_r      <= last_nxt;
      miss_r      <= miss_nxt;
      err_r       <= err_nxt;
      byte_r      <= byte_nxt;
      ready_r     <= ready_nxt;
      set_r       <= set_nxt;
      req_r       <= req_nxt;
      we_r        <= we_nxt;
      adr_r       <= adr_nxt;
      sel_r       <= sel_nxt;
      dat_r       <= dat_nxt;
    end
  end

  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdat_r;
  assign mem_req_o  = req_r;
  assign mem_we_o   = we_r;
  assign mem_adr_o  = adr_r;
  assign mem_sel_o  = sel_r;
  assign mem_dat_o  = dat_r;
  assign rx_ready_o = ready_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Status half of the word being written back, viewed field by field
  rxd_bd_stat_t dat_stat;
  assign dat_stat = rxd_bd_stat_t'(dat_r[31:16]);

  sequence s_stat_done;
    state_r == RXD_ST_RD_STAT && done;
  endsequence
  sequence s_close_done;
    state_r == RXD_ST_CLOSE && done;
  endsequence
  sequence s_close_req;
    state_r == RXD_ST_CLOSE && req_r;
  endsequence

  property p_own_take;
    s_stat_done and mem_dat_i[RXD_BD_E_POS] |=> state_r == RXD_ST_RD_PTR ##[1:1000] req_r;
  endproperty
  a_own_take: assert property (p_own_take) else $error("owned descriptor not used"); // RQ1

  property p_own_skip;
    s_stat_done and !mem_dat_i[RXD_BD_E_POS] |=> state_r == RXD_ST_DROP && set_r[RXD_EVT_BUSY];
  endproperty
  a_own_skip: assert property (p_own_skip) else $error("host-owned descriptor reused"); // RQ2

  property p_close_empty;
    s_close_req |-> !dat_r[RXD_BD_E_POS] && we_r && adr_r == cur_ptr_r;
  endproperty
  a_close_empty: assert property (p_close_empty) else $error("close keeps empty flag"); // RQ2

  property p_wrap;
    s_close_done and stat_r.wrap |=> cur_ptr_r == $past(tbase_r);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not return to base"); // RQ4

  property p_step;
    s_close_done and !stat_r.wrap |=> cur_ptr_r == $past(cur_ptr_r) + RXD_BD_SIZE;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not advance"); // RQ12

  property p_evt_set;
    s_close_done and stat_r.intr |=> (set_r[RXD_EVT_FRM] == $past(last_r)) &&
      (set_r[RXD_EVT_BUF] != $past(last_r)) ##1 (evt_stat[1:0] != 2'b00);
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event bit not set"); // RQ6

  property p_evt_none;
    s_close_done and !stat_r.intr |=> set_r[1:0] == 2'b00;
  endproperty
  a_evt_none: assert property (p_evt_none) else $error("event without interrupt flag"); // RQ7

  property p_last;
    s_close_req |-> dat_stat.last == last_r &&
      (last_r || dat_stat.err == '0);
  endproperty
  a_last: assert property (p_last) else $error("last flag or error bits wrong"); // RQ8

  property p_len;
    s_close_req and last_r |-> dat_r[15:0] == total_r;
  endproperty
  a_len: assert property (p_len) else $error("frame length wrong"); // RQ9

  property p_first;
    s_close_req |-> dat_stat.first == buf_first_r;
  endproperty
  a_first: assert property (p_first) else $error("first flag wrong"); // RQ10

  property p_miss;
    s_close_req and !miss_r |-> !dat_stat.miss;
  endproperty
  a_miss: assert property (p_miss) else $error("miss flag without cause"); // RQ11

endmodule // rxd_top

// >>> core/rxd_pkg.sv
// Constants, types and descriptor layout for the receive descriptor handler
// How it works
// RQ1 - A descriptor whose empty flag is 1 belongs to the engine and may be filled with frame data.
// RQ2 - The engine clears the empty flag when the buffer is full or the frame ended in error, and skips it until set again.
// RQ3 - Once the host sets the empty flag it leaves every field of that descriptor alone until the engine clears it.
// RQ4 - After using a descriptor with the wrap flag set, the engine goes back to the descriptor at the table base pointer.
// RQ5 - The table has no fixed size; only the wrap flag and the memory space bound it.
// RQ6 - A used buffer whose interrupt flag is 1 sets the buffer-received or frame-received event bit, which may raise the interrupt.
// RQ7 - A used buffer whose interrupt flag is 0 raises no event and no interrupt.
// RQ8 - The buffer that ends a frame, or where an error hit, gets the last-in-frame flag, plus the error bits on an error.
// RQ9 - The last buffer of a frame gets the total frame octet count in its length field.
// RQ10 - Only the buffer holding the start of a frame gets the first-in-frame flag.
// RQ11 - In promiscuous mode a frame not matched by address recognition gets the miss flag.
// RQ12 - After a descriptor whose wrap flag is 0, the engine moves to the next descriptor in the table.
package rxd_pkg;

  localparam logic [7:0]  RXD_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  RXD_OFF_TBASE   = 8'h04;
  localparam logic [7:0]  RXD_OFF_BUFLEN  = 8'h08;
  localparam logic [7:0]  RXD_OFF_EVT     = 8'h0C;
  localparam logic [7:0]  RXD_OFF_MASK    = 8'h10;
  localparam logic [7:0]  RXD_OFF_CUR     = 8'h14;

  localparam int          RXD_CTRL_EN     = 0;
  localparam int          RXD_CTRL_PROM   = 1;

  localparam int          RXD_EVT_W       = 3;
  localparam int          RXD_EVT_BUF     = 0;
  localparam int          RXD_EVT_FRM     = 1;
  localparam int          RXD_EVT_BUSY    = 2;

  localparam logic [1:0]  RXD_RST_CTRL    = 2'h0;
  localparam logic [31:0] RXD_RST_TBASE   = 32'h0000_0000;
  localparam logic [15:0] RXD_RST_BUFLEN  = 16'h0600;

  localparam logic [31:0] RXD_BD_SIZE     = 32'h0000_0008;
  localparam logic [31:0] RXD_BD_PTR_OFS  = 32'h0000_0004;
  localparam int          RXD_BD_E_POS    = 31;

  typedef struct packed {
    logic lg;
    logic no;
    logic sh;
    logic cr;
    logic ov;
    logic cl;
  } rxd_err_t;

  // Upper half of descriptor word 0; the lower half is the length
  typedef struct packed {
    logic       empty;
    logic       rsv14;
    logic       wrap;
    logic       intr;
    logic       last;
    logic       first;
    logic       rsv9;
    logic       miss;
    logic [1:0] rsv7_6;
    rxd_err_t   err;
  } rxd_bd_stat_t;

  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eof;
    logic       miss;
    rxd_err_t   err;
  } rxd_rx_t;

  typedef enum {
    RXD_ST_IDLE,
    RXD_ST_RD_STAT,
    RXD_ST_RD_PTR,
    RXD_ST_RECV,
    RXD_ST_WRB,
    RXD_ST_CLOSE,
    RXD_ST_DROP
  } rxd_state_t;

endpackage

// >>> core/rxd_evt.sv
// Sticky event bits with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module rxd_evt #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  input  wire logic         mask_we_i,
  input  wire logic [W-1:0] mask_i,
  output logic      [W-1:0] status_o,
  output logic      [W-1:0] mask_o,
  output logic              irq_o
);

  logic [W-1:0] status_r;
  logic [W-1:0] status_nxt;
  logic [W-1:0] mask_r;
  logic [W-1:0] mask_nxt;
  logic         irq_r;
  logic         irq_nxt;

  if (W < 1) begin : g_chk
    $error("rxd_evt: W must be at least 1");
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    status_nxt = (status_r & ~clr_i) | set_i;
    mask_nxt   = mask_we_i ? mask_i : mask_r;
    irq_nxt    = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= '0;
      mask_r   <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign status_o = status_r;
  assign mask_o   = mask_r;
  assign irq_o    = irq_r;

endmodule // rxd_evt

// >>> verification/rxd_mem_model.sv
// Shared-RAM model of the host side holding descriptors and buffers
`timescale 1ns/1ps
module rxd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_adr_i,
  input  wire logic [3:0]  mem_sel_i,
  input  wire logic [31:0] mem_dat_i,
  output logic      [31:0] mem_dat_o,
  output logic             mem_ack_o
);
  logic [31:0] ram [0:255] = '{default: 32'h0000_0000};
  logic [31:0] rd_r;
  logic [3:0]  wait_r;

  // Outside the ack cycle the read bus shows the inverse of the last word
  assign mem_dat_o = mem_ack_o ? rd_r : ~rd_r;

  // Answers after lat_i idle cycles; one ack per request
  // Plain always: the bench preloads the array before the first edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      wait_r    <= 4'h0;
      rd_r      <= 32'h0000_0000;
    end else if (mem_ack_o || !mem_req_i) begin
      mem_ack_o <= 1'b0;
      wait_r    <= 4'h0;
    end else if (wait_r < lat_i) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      mem_ack_o <= 1'b1;
      rd_r      <= ram[mem_adr_i[9:2]];
      for (int b = 0; b < 4; b++) begin
        if (mem_we_i && mem_sel_i[b]) begin
          ram[mem_adr_i[9:2]][8*b +: 8] <= mem_dat_i[8*b +: 8];
        end
      end
    end
  end
endmodule // rxd_mem_model

// >>> verification/rxd_top_tb_top.sv
// Self-checking bench for the receive descriptor engine
`timescale 1ns/1ps
module rxd_top_tb_top;
  import rxd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        m_req, m_we, m_ack;
  logic [31:0] m_adr, m_wdat, m_rdat;
  logic [3:0]  m_sel;
  logic [3:0]  lat = 4'h0;
  logic        rx_valid = 1'b0;
  rxd_rx_t     rx = '0;
  logic        rx_ready, irq;
  int          fail_count = 0;
  int          checks_done = 0;

  rxd_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mem_req_o(m_req), .mem_we_o(m_we), .mem_adr_o(m_adr), .mem_sel_o(m_sel),
    .mem_dat_o(m_wdat), .mem_dat_i(m_rdat), .mem_ack_i(m_ack),
    .rx_valid_i(rx_valid), .rx_i(rx), .rx_ready_o(rx_ready), .irq_o(irq)
  );

  rxd_mem_model mdl (
    .clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .mem_req_i(m_req), .mem_we_i(m_we),
    .mem_adr_i(m_adr), .mem_sel_i(m_sel), .mem_dat_i(m_wdat), .mem_dat_o(m_rdat),
    .mem_ack_o(m_ack)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Classic single cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdat;
    if (n >= 100) check(1'b0, 1'b1, "bus ack");
    cyc <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(q, exp, what);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Reads a register until the masked value appears or the bound runs out
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    for (int i = 0; i < 200; i++) begin
      wb(1'b0, a, 32'h0000_0000, q);
      if ((q & m) === exp) break;
    end
    check(q & m, exp, "poll");
    repeat (4) @(posedge clk_i);
  endtask

  task automatic send_frame(input int len, input logic [7:0] first, input logic miss,
                            input rxd_err_t err);
    int n;
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx <= '{data: first + 8'(i), sof: (i == 0), eof: (i == len - 1),
              miss: (i == 0) && miss, err: (i == len - 1) ? err : '0};
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (rx_ready !== 1'b1 && n < 200);
      if (n >= 200) check(1'b0, 1'b1, "rx ready");
    end
    rx_valid <= 1'b0;
  endtask

  task automatic test_reset_map();
    rd_chk(RXD_OFF_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(RXD_OFF_BUFLEN, 32'h0000_0600, "buflen reset");
    rd_chk(RXD_OFF_EVT, 32'h0000_0000, "event reset");
    rd_chk(RXD_OFF_MASK, 32'h0000_0000, "mask reset");
    rd_chk(RXD_OFF_CUR, 32'h0000_0000, "cur reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    wr(RXD_OFF_TBASE, 32'h0000_0100);
    wr(RXD_OFF_BUFLEN, 32'h0000_0004);
    wr(RXD_OFF_MASK, 32'h0000_0003);
    wr(RXD_OFF_CUR, 32'h0000_0040);
    rd_chk(RXD_OFF_CUR, 32'h0000_0100, "cur follows base");
    wr(RXD_OFF_CTRL, 32'h0000_0003);
  endtask

  // Six bytes over two four-byte buffers, missed address, prompt memory
  task automatic test_two_buffers();
    send_frame(6, 8'h11, 1'b1, '0);
    poll(RXD_OFF_CUR, 32'hFFFF_FFFF, 32'h0000_0110);
    check(mdl.ram[64], 32'h1400_0004, "first buffer close");
    check(mdl.ram[66], 32'h1900_0006, "last buffer close");
    check(mdl.ram[66][24], 1'b1, "miss flag");
    check(mdl.ram[128], 32'h1413_1211, "first buffer data");
    check(mdl.ram[192][15:0], 16'h1615, "second buffer data");
    rd_chk(RXD_OFF_EVT, 32'h0000_0003, "events with intr set");
    check(irq, 1'b1, "irq raised");
    wr(RXD_OFF_EVT, 32'h0000_0003);
    rd_chk(RXD_OFF_EVT, 32'h0000_0000, "events cleared");
    check(irq, 1'b0, "irq cleared");
  endtask

  // Error frame into the wrap descriptor, no intr, slow memory, promiscuous off
  task automatic test_error_wrap();
    rxd_err_t e;
    e = '0;
    e.cr = 1'b1;
    wr(RXD_OFF_CTRL, 32'h0000_0001);
    lat <= 4'h3;
    send_frame(2, 8'h21, 1'b1, e);
    poll(RXD_OFF_CUR, 32'hFFFF_FFFF, 32'h0000_0100);
    check(mdl.ram[68], 32'h2C04_0002, "error close, no miss");
    check(mdl.ram[68][24], 1'b0, "miss ignored off promiscuous");
    check(mdl.ram[224][15:0], 16'h2221, "wrap buffer data");
    rd_chk(RXD_OFF_EVT, 32'h0000_0000, "no event without intr");
    check(irq, 1'b0, "no irq without intr");
  endtask

  // Head descriptor still host-owned: frame dropped, busy event masked then seen
  task automatic test_not_empty();
    lat <= 4'h0;
    send_frame(1, 8'h31, 1'b0, '0);
    poll(RXD_OFF_EVT, 32'h0000_0004, 32'h0000_0004);
    check(mdl.ram[128], 32'h1413_1211, "owned buffer untouched");
    check(mdl.ram[64], 32'h1400_0004, "owned descriptor untouched");
    rd_chk(RXD_OFF_CUR, 32'h0000_0100, "cur held on drop");
    check(irq, 1'b0, "busy masked");
    wr(RXD_OFF_MASK, 32'h0000_0007);
    check(irq, 1'b1, "busy unmasked");
    wr(RXD_OFF_EVT, 32'h0000_0004);
    check(irq, 1'b0, "busy cleared");
  endtask

  initial begin
    // Host fills the ring only while it still owns every descriptor
    #1;
    mdl.ram[64] = 32'h9000_0000;
    mdl.ram[65] = 32'h0000_0200;
    mdl.ram[66] = 32'h9000_0000;
    mdl.ram[67] = 32'h0000_0300;
    mdl.ram[68] = 32'hA000_0000;
    mdl.ram[69] = 32'h0000_0380;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset_map();
    test_two_buffers();
    test_error_wrap();
    test_not_empty();
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
endmodule // rxd_top_tb_top
